// ### include/pwmcs_pkg.sv
// constants shared by the chained modulator block
package pwmcs_pkg;
    // counter width, channel count and words per channel
    localparam int PWMCS_CW = 16;
    localparam int PWMCS_NCH = 4;
    localparam int PWMCS_NCFG = 9;
    // per-channel word indices inside a channel window
    localparam logic [3:0] PWMCS_IX_CTRL = 4'h0;
    localparam logic [3:0] PWMCS_IX_PERIOD = 4'h1;
    localparam logic [3:0] PWMCS_IX_EV1 = 4'h2;
    localparam logic [3:0] PWMCS_IX_EV2 = 4'h3;
    localparam logic [3:0] PWMCS_IX_EV3 = 4'h4;
    localparam logic [3:0] PWMCS_IX_EV4 = 4'h5;
    localparam logic [3:0] PWMCS_IX_PHASE = 4'h6;
    localparam logic [3:0] PWMCS_IX_BLKB_BEG = 4'h7;
    localparam logic [3:0] PWMCS_IX_BLKB_END = 4'h8;
    // global byte offsets; channel n window at n * 0x40
    localparam logic [11:0] PWMCS_OFF_ROUTING = 12'h0100;
    localparam logic [11:0] PWMCS_OFF_STATUS = 12'h0104;
    // channel_control_word fields
    localparam int PWMCS_CTL_FOLLOW = 0;
    localparam int PWMCS_CTL_ASEL_LO = 4;
    localparam int PWMCS_CTL_BSEL_LO = 8;
    // sync_source_routing fields, 2 bits each
    localparam int PWMCS_RT_CH1_LO = 0;
    localparam int PWMCS_RT_CH2_LO = 2;
    localparam int PWMCS_RT_CH3_LO = 4;
    // output selector codes
    localparam logic [3:0] PWMCS_SEL_CH1_C = 4'h7;
    localparam logic [3:0] PWMCS_SEL_CH2_C = 4'h8;
    // reset values
    localparam logic [15:0] PWMCS_RST_CFG = 16'h0000;
    localparam logic [15:0] PWMCS_RST_PERIOD = 16'h0280;
    localparam logic [5:0] PWMCS_RST_ROUTING = 6'h3f;
endpackage

// ### core/pwmcs_channel.sv
// one modulator channel: counter, follow sync, A/B/C waves, fault gate
`timescale 1ns/10ps
module pwmcs_channel
    import pwmcs_pkg::*;
#(
    parameter int CW = PWMCS_CW
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [CW-1:0] period,
    input  wire logic [CW-1:0] ev1,
    input  wire logic [CW-1:0] ev2,
    input  wire logic [CW-1:0] ev3,
    input  wire logic [CW-1:0] ev4,
    input  wire logic [CW-1:0] phase_trigger_time,
    input  wire logic [CW-1:0] blank_b_begin_time,
    input  wire logic [CW-1:0] blank_b_end_time,
    input  wire logic          follow_master_enable,
    input  wire logic          sync_in,
    input  wire logic          fault,
    output logic      [CW-1:0] cnt,
    output logic               phase_pulse,
    output logic               wave_a,
    output logic               wave_b,
    output logic               aux_c
);
    logic [CW-1:0] next_cnt;

    // period counter, restarted by the master when following
    always_comb begin
        if (follow_master_enable && sync_in) begin
            next_cnt = '0;
        end else if (cnt >= period - CW'(1)) begin
            next_cnt = '0;
        end else begin
            next_cnt = cnt + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else begin
            cnt <= next_cnt;
        end
    end

    // phase trigger toward the next channel in the chain
    assign phase_pulse = (cnt == phase_trigger_time);

    // waves after the fault stage; C timed by blanking-B words only
    assign wave_a = (cnt >= ev1) && (cnt < ev2) && !fault;
    assign wave_b = (cnt >= ev3) && (cnt < ev4) && !fault;
    assign aux_c = (cnt >= blank_b_begin_time)
                && (cnt < blank_b_end_time) && !fault;

    // C is high at the blanking-B begin count when not faulted
    a_aux_window: assert property (@(posedge pclk) disable iff (!presetn)
        (cnt == blank_b_begin_time && blank_b_begin_time < blank_b_end_time
         && !fault) |-> aux_c)
        else $error("aux C not high at blanking-B begin");
endmodule

// ### core/pwmcs_top.sv
// four chained modulator channels with APB registers and aux routing
//
// What this block does
// - channel 1 follows channel 0, 2 follows 1, 3 follows 2, each offset.
// - a channel restarts on a master pulse only with its follow bit set.
// - master select value 0, 1, 2 picks channel 0, 1, 2 as master.
// - channels with identical event words give symmetrical output pairs.
// - each channel's C wave comes after its fault stage, like A and B.
// - C of channels 1 and 2 drive the fixed bridge gates, loop-independent.
// - channel 3 A selector 7 sends channel 1 C; B selector 8 channel 2 C.
// - C on and off times come from the blanking-B begin and end words.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/10ps
module pwmcs_top
    import pwmcs_pkg::*;
#(
    parameter int CW = PWMCS_CW
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        fault_in,
    output logic      [3:0]  pin_first,
    output logic      [3:0]  pin_second
);
    localparam int NCH = PWMCS_NCH;
    localparam int NCFG = PWMCS_NCFG;

    logic [15:0] cfg [NCH][NCFG];
    logic [15:0] next_cfg [NCH][NCFG];
    logic [5:0]  sync_source_routing;
    logic [5:0]  next_routing;
    logic [31:0] next_prdata;
    logic        next_pready;
    logic        next_pslverr;
    logic        fault_meta;
    logic        fault_s;
    logic [3:0]  next_first;
    logic [3:0]  next_second;
    logic [CW-1:0] cnt [NCH];
    logic [NCH-1:0] phase_pulse;
    logic [NCH-1:0] wave_a;
    logic [NCH-1:0] wave_b;
    logic [NCH-1:0] aux_c;
    logic [NCH-1:0] sync_in;
    logic [1:0]  chan1_master_select;
    logic [1:0]  chan2_master_select;
    logic [1:0]  chan3_master_select;
    logic        in_chan;
    logic [1:0]  a_ch;
    logic [3:0]  a_ix;
    logic        wr_en;

    // address decode
    assign in_chan = (paddr[11:8] == 4'h0) && (paddr[1:0] == 2'h0);
    assign a_ch = paddr[7:6];
    assign a_ix = paddr[5:2];
    assign wr_en = psel && penable && pready && pwrite;
    assign chan1_master_select = sync_source_routing[PWMCS_RT_CH1_LO +: 2];
    assign chan2_master_select = sync_source_routing[PWMCS_RT_CH2_LO +: 2];
    assign chan3_master_select = sync_source_routing[PWMCS_RT_CH3_LO +: 2];

    // register writes on the completing access cycle
    always_comb begin
        next_cfg = cfg;
        next_routing = sync_source_routing;
        if (wr_en) begin
            if (in_chan && a_ix < 4'(NCFG)) begin
                next_cfg[a_ch][a_ix] = pwdata[15:0];
            end else if (paddr == PWMCS_OFF_ROUTING) begin
                next_routing = pwdata[5:0];
            end
        end
    end

    // read data and answer, prepared in the setup cycle
    always_comb begin
        next_prdata = '0;
        next_pslverr = 1'b0;
        next_pready = psel && !penable;
        if (in_chan && a_ix < 4'(NCFG)) begin
            next_prdata = {16'h0000, cfg[a_ch][a_ix]};
        end else if (paddr == PWMCS_OFF_ROUTING) begin
            next_prdata = {26'h000_0000, sync_source_routing};
        end else if (paddr == PWMCS_OFF_STATUS) begin
            next_prdata = {23'h00_0000, fault_s, pin_second, pin_first};
        end else begin
            next_pslverr = psel && !penable;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int c = 0; c < NCH; c++) begin
                for (int i = 0; i < NCFG; i++) begin
                    cfg[c][i] <= (i == int'(PWMCS_IX_PERIOD))
                               ? PWMCS_RST_PERIOD : PWMCS_RST_CFG;
                end
            end
            sync_source_routing <= PWMCS_RST_ROUTING;
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            cfg <= next_cfg;
            sync_source_routing <= next_routing;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // fault pin synchroniser
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_meta <= 1'b0;
            fault_s <= 1'b0;
        end else begin
            fault_meta <= fault_in;
            fault_s <= fault_meta;
        end
    end

    // master pulse selection per slave
    function automatic logic pick(input logic [1:0] sel,
                                  input logic [NCH-1:0] pulses);
        pick = (sel < 2'h3) ? pulses[sel] : 1'b0;
    endfunction

    assign sync_in[0] = 1'b0;
    assign sync_in[1] = pick(chan1_master_select, phase_pulse);
    assign sync_in[2] = pick(chan2_master_select, phase_pulse);
    assign sync_in[3] = pick(chan3_master_select, phase_pulse);

    // identical channels give symmetrical pairs
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        pwmcs_channel #(.CW(CW)) u_ch (
            .pclk                 (pclk),
            .presetn              (presetn),
            .period               (cfg[g][PWMCS_IX_PERIOD][CW-1:0]),
            .ev1                  (cfg[g][PWMCS_IX_EV1][CW-1:0]),
            .ev2                  (cfg[g][PWMCS_IX_EV2][CW-1:0]),
            .ev3                  (cfg[g][PWMCS_IX_EV3][CW-1:0]),
            .ev4                  (cfg[g][PWMCS_IX_EV4][CW-1:0]),
            .phase_trigger_time   (cfg[g][PWMCS_IX_PHASE][CW-1:0]),
            .blank_b_begin_time   (cfg[g][PWMCS_IX_BLKB_BEG][CW-1:0]),
            .blank_b_end_time     (cfg[g][PWMCS_IX_BLKB_END][CW-1:0]),
            .follow_master_enable (cfg[g][PWMCS_IX_CTRL][PWMCS_CTL_FOLLOW]),
            .sync_in              (sync_in[g]),
            .fault                (fault_s),
            .cnt                  (cnt[g]),
            .phase_pulse          (phase_pulse[g]),
            .wave_a               (wave_a[g]),
            .wave_b               (wave_b[g]),
            .aux_c                (aux_c[g])
        );
    end

    // output selectors route faulted C of channels 1 and 2 to pins
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            case (cfg[c][PWMCS_IX_CTRL][PWMCS_CTL_ASEL_LO +: 4])
                PWMCS_SEL_CH1_C: next_first[c] = aux_c[1];
                PWMCS_SEL_CH2_C: next_first[c] = aux_c[2];
                default:         next_first[c] = wave_a[c];
            endcase
            case (cfg[c][PWMCS_IX_CTRL][PWMCS_CTL_BSEL_LO +: 4])
                PWMCS_SEL_CH1_C: next_second[c] = aux_c[1];
                PWMCS_SEL_CH2_C: next_second[c] = aux_c[2];
                default:         next_second[c] = wave_b[c];
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_first <= '0;
            pin_second <= '0;
        end else begin
            pin_first <= next_first;
            pin_second <= next_second;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_chain_restart: assert property (
        phase_pulse[0] && chan1_master_select == 2'h0
        && cfg[1][PWMCS_IX_CTRL][PWMCS_CTL_FOLLOW] |=> cnt[1] == '0)
        else $error("channel 1 did not restart on channel 0 pulse");
    a_no_follow: assert property (
        !cfg[1][PWMCS_IX_CTRL][PWMCS_CTL_FOLLOW] && !wr_en
        && cnt[1] < cfg[1][PWMCS_IX_PERIOD][CW-1:0] - CW'(1)
        |=> cnt[1] == $past(cnt[1]) + CW'(1))
        else $error("channel 1 moved without follow enable");
    a_select_two: assert property (
        phase_pulse[2] && chan3_master_select == 2'h2
        && cfg[3][PWMCS_IX_CTRL][PWMCS_CTL_FOLLOW] |=> cnt[3] == '0)
        else $error("channel 3 missed channel 2 as master");
    a_pair_symmetry: assert property (
        cnt[0] == cnt[1] && cfg[0][PWMCS_IX_EV1] == cfg[1][PWMCS_IX_EV1]
        && cfg[0][PWMCS_IX_EV2] == cfg[1][PWMCS_IX_EV2]
        |-> wave_a[0] == wave_a[1])
        else $error("identical channels gave different A waves");
    a_fault_kills_c: assert property (
        fault_s |-> !aux_c[1] && !aux_c[2])
        else $error("aux C active during fault");
    a_fixed_gate: assert property (
        cfg[3][PWMCS_IX_CTRL][PWMCS_CTL_BSEL_LO +: 4] == PWMCS_SEL_CH2_C
        && !wr_en |=> pin_second[3] == $past(aux_c[2]))
        else $error("channel 3 second pin not fed by channel 2 C");
    a_route_first: assert property (
        cfg[3][PWMCS_IX_CTRL][PWMCS_CTL_ASEL_LO +: 4] == PWMCS_SEL_CH1_C
        && !wr_en |=> pin_first[3] == $past(aux_c[1]))
        else $error("channel 3 first pin not fed by channel 1 C");
    a_c_off_end: assert property (
        cnt[1] == cfg[1][PWMCS_IX_BLKB_END][CW-1:0] |-> !aux_c[1])
        else $error("aux C still high at blanking-B end");
endmodule

// ### test/pwmcs_gate_drv.sv
// gate driver side: records the bridge pin levels each cycle
`timescale 1ns/10ps
module pwmcs_gate_drv (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic [3:0]        pin_first,
    input  wire logic [3:0]        pin_second,
    output logic      [255:0][7:0] hist
);
    // shift register of past pin samples, newest at index 0
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist <= '0;
        end else begin
            hist <= {hist[254:0], pin_second, pin_first};
        end
    end
endmodule

// ### test/pwm_chain_sync_and_aux_route_test.sv
// bench for the chained modulator block: apb config, pin phase checks
`timescale 1ns/10ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
    num_errors++; $display("Error %s exp %0h got %0h", n, e, g); end end
module pwm_chain_sync_and_aux_route_test;
    import pwmcs_pkg::*;
    logic              pclk = 1'b0;
    logic              presetn = 1'b0;
    logic              psel = 1'b0;
    logic              penable = 1'b0;
    logic              pwrite = 1'b0;
    logic [11:0]       paddr = '0;
    logic [31:0]       pwdata = '0;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
    logic              fault_in = 1'b0;
    logic [3:0]        pin_first;
    logic [3:0]        pin_second;
    logic [255:0][7:0] hist;
    logic [31:0]       rdat;
    logic              rerr;
    logic [31:0]       seed = 32'h0000_001f;
    logic [15:0]       b1, e1, b2, e2;
    int                num_errors = 0;
    int                checked = 0;
    int                c1_hi = 0;
    int                c2_hi = 0;

    // 100 MHz clock
    always #5 pclk = ~pclk;

    pwmcs_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .fault_in(fault_in), .pin_first(pin_first),
        .pin_second(pin_second));
    pwmcs_gate_drv gates (.pclk(pclk), .presetn(presetn),
        .pin_first(pin_first), .pin_second(pin_second), .hist(hist));

    // xorshift source for event times
    function automatic logic [15:0] rnd(input int m);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return 16'(seed % m);
    endfunction

    function automatic logic [11:0] ad(input int n, input logic [3:0] ix);
        return 12'(n * 64 + ix * 4);
    endfunction

    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) num_errors++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, '0);
        `CHK("prdata", e, rdat)
    endtask

    // channel k pins against channel r pins delayed by lag cycles
    task automatic chk_lag(input int k, input int r, input int lag);
        for (int i = 0; i < 160; i++) begin
            @(posedge pclk);
            #1;
            `CHK("pin_a", hist[lag][r], hist[0][k])
            `CHK("pin_b", hist[lag][r+4], hist[0][k+4])
        end
    endtask

    task automatic wrap_up;
        $display("checked %0d num_errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end

    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        for (int n = 0; n < 3; n++) apb(1'b1, ad(n, PWMCS_IX_PERIOD), 160);
        rd(ad(3, PWMCS_IX_PERIOD), 32'(PWMCS_RST_PERIOD));
        apb(1'b1, ad(3, PWMCS_IX_PERIOD), 160);
        rd(ad(1, PWMCS_IX_CTRL), 32'h0000_0000);
        rd(PWMCS_OFF_ROUTING, 32'h0000_003f);
        rd(12'h108, 32'h0000_0000);
        `CHK("pslverr", 1'b1, rerr)
        // address above the map must not alias onto a channel window
        rd(12'h208, 32'h0000_0000);
        `CHK("pslverr_hi", 1'b1, rerr)
        // blanking-B of channel 1 copies events 1 and 2, of channel 2 events 3 and 4
        b1 = rnd(20) + 16'h0040;
        e1 = b1 + 16'h0001 + rnd(40);
        b2 = rnd(20) + 16'h0054;
        e2 = b2 + 16'h0001 + rnd(50);
        for (int n = 0; n < 4; n++) begin
            apb(1'b1, ad(n, PWMCS_IX_EV1), 32'(b1));
            apb(1'b1, ad(n, PWMCS_IX_EV2), 32'(e1));
            apb(1'b1, ad(n, PWMCS_IX_EV3), 32'(b2));
            apb(1'b1, ad(n, PWMCS_IX_EV4), 32'(e2));
            apb(1'b1, ad(n, PWMCS_IX_PHASE), 79);
        end
        apb(1'b1, ad(1, PWMCS_IX_BLKB_BEG), 32'(b1));
        apb(1'b1, ad(1, PWMCS_IX_BLKB_END), 32'(e1));
        apb(1'b1, ad(2, PWMCS_IX_BLKB_BEG), 32'(b2));
        apb(1'b1, ad(2, PWMCS_IX_BLKB_END), 32'(e2));
        apb(1'b1, PWMCS_OFF_ROUTING, 32'h0000_0024);
        repeat (200) @(posedge pclk);
        // follow bits clear: no restart, channels stay in phase
        for (int k = 1; k < 4; k++) chk_lag(k, 0, 0);
        for (int n = 1; n < 4; n++) apb(1'b1, ad(n, PWMCS_IX_CTRL), 1);
        repeat (400) @(posedge pclk);
        for (int k = 1; k < 4; k++) chk_lag(k, k - 1, 80);
        // master select codes 0 to 2 on the last channel
        for (int m = 0; m < 3; m++) begin
            apb(1'b1, PWMCS_OFF_ROUTING, 32'(6'h24 & 6'h0f | m << 4));
            repeat (400) @(posedge pclk);
            chk_lag(3, m, 80);
        end
        // aux C of channels 1 and 2 onto the last channel's pins
        apb(1'b1, ad(3, PWMCS_IX_CTRL), 32'h0000_0871);
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 160; i++) begin
            @(posedge pclk);
            #1;
            `CHK("c1_route", hist[0][1], hist[0][3])
            `CHK("c2_route", hist[0][6], hist[0][7])
            c1_hi += int'(hist[0][3]);
            c2_hi += int'(hist[0][7]);
        end
        // routed C high for exactly end minus begin counts per period
        `CHK("c1_width", int'(e1 - b1), c1_hi)
        `CHK("c2_width", int'(e2 - b2), c2_hi)
        // fault forces A, B and routed C low
        @(posedge pclk);
        fault_in <= 1'b1;
        repeat (5) @(posedge pclk);
        for (int i = 0; i < 170; i++) begin
            @(posedge pclk);
            #1;
            `CHK("fault_pins", 8'h00, hist[0])
        end
        rd(PWMCS_OFF_STATUS, 32'h0000_0100);
        fault_in <= 1'b0;
        wrap_up();
    end
endmodule
